// ==== hw/puih_dev_end.sv ====
/*
 * puih_dev_end: interrupt aggregation on the device; turns user and dma
 * interrupt wires into legacy, msi or msi-x messages toward the pcie
 * core, with a per-bit acknowledge back to user logic.
 * assumes: pcie core takes one message per msg_valid&&msg_ready;
 * config inputs are same-clock and steady while interrupts pend.
 */
// How it works
// - takes user requests plus dma channel wires
// - one type only, msix over msi over legacy
// - host keeps type steady while pending
// - legacy assert message on raised request
// - user holds request until its ack
// - legacy request held until ack and service
// - ack only after core takes message
// - legacy drop sends deassert, acks again
// - pending indication follows held request
// - each source routed to inta..intd
// - msi or msix message, msix preferred
// - msi request held until ack and service
// - vector mapping, msix table and pending bits
// - user detects host service itself
// - config info readable at fixed offsets
`timescale 1ns/1ps
module puih_dev_end (
    input wire logic clk,
    input wire logic rst_n,
    puih_if.dev link,
    input wire logic [puih_pkg::DMA_W-1:0] dma_channel_irq,
    input wire logic leg_en,
    input wire logic msi_en,
    input wire logic msix_en,
    input wire logic [puih_pkg::SRC_W*puih_pkg::INTX_W-1:0] intx_map,
    input wire logic [puih_pkg::SRC_W*puih_pkg::VEC_W-1:0] vec_map,
    input wire logic [puih_pkg::SRC_W-1:0] msix_vec_mask,
    input wire logic msg_ready,
    output logic msg_valid,
    output puih_pkg::puih_msg_t msg_kind,
    output logic [puih_pkg::VEC_W-1:0] msg_vector,
    output logic [puih_pkg::INTX_W-1:0] msg_intx,
    output logic [puih_pkg::LINE_N-1:0] intx_level,
    input wire logic [7:0] cfg_addr,
    output logic [31:0] cfg_rdata,
    output logic [puih_pkg::SRC_W-1:0] pending,
    output logic [puih_pkg::SRC_W-1:0] pending_bit_array
);
    import puih_pkg::*;
    logic [SRC_W-1:0] src;
    puih_mode_t mode;
    puih_bit_t bst_q [SRC_W];
    logic [SRC_W-1:0] want;
    logic [SRC_IDX_W-1:0] pick;
    logic pick_ok;
    logic [SRC_IDX_W-1:0] cur_q;
    logic [USR_W-1:0] ack_q;
    logic msg_valid_q;
    puih_msg_t msg_kind_q;
    logic [VEC_W-1:0] msg_vector_q;
    logic [INTX_W-1:0] msg_intx_q;
    logic [LINE_N-1:0] intx_q;
    logic [SRC_W-1:0] pend_q;
    logic [SRC_W-1:0] pend_arr_q;
    logic [31:0] rdata_q;
    logic [LINE_N-1:0] line_d;
    logic done;

    assign src = {dma_channel_irq, link.engine_user_interrupt_request};

    always_comb begin
        if (msix_en) begin
            mode = PUIH_MODE_MSIX;
        end else if (msi_en) begin
            mode = PUIH_MODE_MSI;
        end else if (leg_en) begin
            mode = PUIH_MODE_LEG;
        end else begin
            mode = PUIH_MODE_NONE;
        end
    end

    // a source wants a message when raised while idle, or dropped
    // in legacy mode while its assert stands
    always_comb begin
        for (int i = 0; i < SRC_W; i++) begin
            want[i] = (bst_q[i] == PUIH_B_IDLE && src[i]
                       && mode != PUIH_MODE_NONE)
                   || (bst_q[i] == PUIH_B_HELD && !src[i]
                       && mode == PUIH_MODE_LEG);
        end
    end

    // lowest index first; fixed priority is fair enough since a bit
    // cannot re-request before its own ack
    always_comb begin
        pick = '0;
        pick_ok = 1'b0;
        for (int i = SRC_W - 1; i >= 0; i--) begin
            if (want[i]) begin
                pick = SRC_IDX_W'(i);
                pick_ok = 1'b1;
            end
        end
    end

    assign done = msg_valid_q && msg_ready;

    for (genvar i = 0; i < SRC_W; i++) begin : g_src
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                bst_q[i] <= PUIH_B_IDLE;
            end else begin
                case (bst_q[i])
                    PUIH_B_IDLE: begin
                        if (!msg_valid_q && pick_ok
                            && pick == SRC_IDX_W'(i)) begin
                            bst_q[i] <= PUIH_B_SENT;
                        end
                    end
                    PUIH_B_SENT: begin
                        if (done && cur_q == SRC_IDX_W'(i)) begin
                            bst_q[i] <= PUIH_B_HELD;
                        end
                    end
                    PUIH_B_HELD: begin
                        if (!msg_valid_q && pick_ok
                            && pick == SRC_IDX_W'(i)) begin
                            bst_q[i] <= PUIH_B_DROP;
                        end else if (!src[i]
                                     && mode != PUIH_MODE_LEG) begin
                            bst_q[i] <= PUIH_B_IDLE;
                        end
                    end
                    PUIH_B_DROP: begin
                        if (done && cur_q == SRC_IDX_W'(i)) begin
                            bst_q[i] <= PUIH_B_IDLE;
                        end
                    end
                    default: begin
                        bst_q[i] <= PUIH_B_IDLE;
                    end
                endcase
            end
        end
    end

    // message launch toward the core
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msg_valid_q <= 1'b0;
            msg_kind_q <= PUIH_MSG_LEG_ASSERT;
            msg_vector_q <= VEC_RST;
            msg_intx_q <= INTX_RST;
            cur_q <= '0;
        end else if (done) begin
            msg_valid_q <= 1'b0;
        end else if (!msg_valid_q && pick_ok) begin
            msg_valid_q <= 1'b1;
            cur_q <= pick;
            msg_intx_q <= intx_map[pick*INTX_W +: INTX_W];
            msg_vector_q <= vec_map[pick*VEC_W +: VEC_W];
            case (mode)
                PUIH_MODE_MSIX: msg_kind_q <= PUIH_MSG_MSIX;
                PUIH_MODE_MSI: msg_kind_q <= PUIH_MSG_MSI;
                default: begin
                    msg_kind_q <= (bst_q[pick] == PUIH_B_HELD)
                        ? PUIH_MSG_LEG_DEASSERT : PUIH_MSG_LEG_ASSERT;
                end
            endcase
        end
    end

    // ack one cycle after core takes it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= '0;
        end else begin
            for (int i = 0; i < USR_W; i++) begin
                ack_q[i] <= done && cur_q == SRC_IDX_W'(i);
            end
        end
    end

    // legacy line levels: or of held sources per line
    always_comb begin
        line_d = '0;
        for (int i = 0; i < SRC_W; i++) begin
            if (bst_q[i] == PUIH_B_HELD || bst_q[i] == PUIH_B_DROP) begin
                line_d[intx_map[i*INTX_W +: INTX_W]] = 1'b1;
            end
        end
        if (mode != PUIH_MODE_LEG) begin
            line_d = '0;
        end
    end

    // pending follows request; pending array when masked, in msix mode only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= '0;
            pend_arr_q <= '0;
            intx_q <= '0;
        end else begin
            pend_q <= src;
            pend_arr_q <= (mode == PUIH_MODE_MSIX)
                ? (src & msix_vec_mask) : '0;
            intx_q <= line_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else begin
            case (cfg_addr)
                CFG_OFS_MODE: rdata_q <= 32'(mode);
                CFG_OFS_PEND: rdata_q <= 32'(pend_q);
                CFG_OFS_PEND_ARR: rdata_q <= 32'(pend_arr_q);
                CFG_OFS_INTX: rdata_q <= 32'(intx_map);
                default: rdata_q <= '0;
            endcase
        end
    end

    assign link.user_interrupt_ack = ack_q;
    assign msg_valid = msg_valid_q;
    assign msg_kind = msg_kind_q;
    assign msg_vector = msg_vector_q;
    assign msg_intx = msg_intx_q;
    assign intx_level = intx_q;
    assign pending = pend_q;
    assign pending_bit_array = pend_arr_q;
    assign cfg_rdata = rdata_q;
endmodule : puih_dev_end

// ==== hw/puih_if.sv ====
/*
 * puih_if: request/acknowledge wires between user logic and the
 * interrupt block.
 * assumes: both ends clocked by the same clk.
 */
`timescale 1ns/1ps
interface puih_if;
    import puih_pkg::*;
    logic [USR_W-1:0] engine_user_interrupt_request;
    logic [USR_W-1:0] user_interrupt_ack;
    modport dev (
        input engine_user_interrupt_request,
        output user_interrupt_ack
    );
    modport usr (
        output engine_user_interrupt_request,
        input user_interrupt_ack
    );
endinterface : puih_if

// ==== hw/puih_pkg.sv ====
/*
 * puih_pkg: shared constants and types for the user interrupt handshake
 * block and its user-side partner.
 * assumes: single clock domain, both ends on the same clk.
 */
package puih_pkg;
    localparam int USR_W = 4;
    localparam int DMA_W = 2;
    localparam int SRC_W = USR_W + DMA_W;
    localparam int VEC_W = 5;
    localparam int SRC_IDX_W = 3;
    localparam int INTX_W = 2;
    localparam int LINE_N = 4;
    // message kinds toward the pcie core
    typedef enum logic [1:0] {
        PUIH_MSG_LEG_ASSERT = 2'h0,
        PUIH_MSG_LEG_DEASSERT = 2'h1,
        PUIH_MSG_MSI = 2'h2,
        PUIH_MSG_MSIX = 2'h3
    } puih_msg_t;
    // active interrupt type
    typedef enum logic [1:0] {
        PUIH_MODE_NONE = 2'h0,
        PUIH_MODE_LEG = 2'h1,
        PUIH_MODE_MSI = 2'h3,
        PUIH_MODE_MSIX = 2'h2
    } puih_mode_t;
    // per-request-bit tracking on the device side
    typedef enum logic [1:0] {
        PUIH_B_IDLE = 2'h0,
        PUIH_B_SENT = 2'h1,
        PUIH_B_HELD = 2'h3,
        PUIH_B_DROP = 2'h2
    } puih_bit_t;
    // user-end request states
    typedef enum logic [1:0] {
        PUIH_U_IDLE = 2'h0,
        PUIH_U_WAIT = 2'h1,
        PUIH_U_HOLD = 2'h3,
        PUIH_U_REL = 2'h2
    } puih_usr_t;
    localparam logic [VEC_W-1:0] VEC_RST = 5'h00;
    localparam logic [INTX_W-1:0] INTX_RST = 2'h0;
    // config readout offsets inside the dma register space
    localparam logic [7:0] CFG_OFS_MODE = 8'h00;
    localparam logic [7:0] CFG_OFS_PEND = 8'h04;
    localparam logic [7:0] CFG_OFS_PEND_ARR = 8'h08;
    localparam logic [7:0] CFG_OFS_INTX = 8'h0c;
endpackage : puih_pkg

// ==== hw/puih_user_end.sv ====
/*
 * puih_user_end: user application side; raises one request bit per
 * event and releases it after ack and host service.
 * assumes: raise/serviced pulses come from same-clock user logic.
 */
`timescale 1ns/1ps
module puih_user_end (
    input wire logic clk,
    input wire logic rst_n,
    puih_if.usr link,
    input wire logic legacy_mode,
    input wire logic [puih_pkg::USR_W-1:0] raise,
    input wire logic [puih_pkg::USR_W-1:0] serviced,
    output logic [puih_pkg::USR_W-1:0] busy
);
    import puih_pkg::*;
    puih_usr_t st_q [USR_W];
    logic [USR_W-1:0] req_q;
    logic [USR_W-1:0] busy_q;
    assign link.engine_user_interrupt_request = req_q;
    assign busy = busy_q;
    for (genvar i = 0; i < USR_W; i++) begin : g_bit
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                st_q[i] <= PUIH_U_IDLE;
                req_q[i] <= 1'b0;
                busy_q[i] <= 1'b0;
            end else begin
                case (st_q[i])
                    PUIH_U_IDLE: begin
                        if (raise[i]) begin
                            st_q[i] <= PUIH_U_WAIT;
                            req_q[i] <= 1'b1;
                            busy_q[i] <= 1'b1;
                        end
                    end
                    PUIH_U_WAIT: begin
                        if (link.user_interrupt_ack[i]) begin
                            st_q[i] <= PUIH_U_HOLD;
                        end
                    end
                    PUIH_U_HOLD: begin
                        if (serviced[i]) begin
                            req_q[i] <= 1'b0;
                            if (legacy_mode) begin
                                st_q[i] <= PUIH_U_REL;
                            end else begin
                                st_q[i] <= PUIH_U_IDLE;
                                busy_q[i] <= 1'b0;
                            end
                        end
                    end
                    PUIH_U_REL: begin
                        if (link.user_interrupt_ack[i]) begin
                            st_q[i] <= PUIH_U_IDLE;
                            busy_q[i] <= 1'b0;
                        end
                    end
                    default: begin
                        st_q[i] <= PUIH_U_IDLE;
                        req_q[i] <= 1'b0;
                        busy_q[i] <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule : puih_user_end

// ==== testbench/puih_props.sv ====
/*
 * puih_props: concurrent checks on the request/ack link and message port.
 * assumes: one clk; the bench instances it beside the link interface.
 */
`timescale 1ns/1ps
module puih_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [puih_pkg::USR_W-1:0] engine_user_interrupt_request,
    input wire logic [puih_pkg::USR_W-1:0] user_interrupt_ack,
    input wire logic leg_en,
    input wire logic msi_en,
    input wire logic msix_en,
    input wire logic msg_valid,
    input wire logic msg_ready,
    input wire puih_pkg::puih_msg_t msg_kind,
    input wire logic [puih_pkg::SRC_W-1:0] pending
);
    import puih_pkg::*;
    logic [USR_W-1:0] req, ack, got_q, drop_q;
    logic leg_only;
    assign req = engine_user_interrupt_request;
    assign ack = user_interrupt_ack;
    assign leg_only = leg_en && !msi_en && !msix_en;
    // bit acked while high; cleared once the user lets go
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            got_q <= '0;
        end else begin
            got_q <= (got_q | (ack & req)) & req;
        end
    end
    // legacy drop still waiting for its second ack
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drop_q <= '0;
        end else begin
            drop_q <= (drop_q & ~ack) | ({USR_W{leg_only}} & got_q & ~req);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_ack_after_take;
        ack != '0 |-> $past(msg_valid && msg_ready);
    endproperty
    a_ack_after_take: assert property (p_ack_after_take)
        else $error("ack without an accepted message");
    property p_ack_pulse;
        ack != '0 |=> (ack & $past(ack)) == '0;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    property p_msg_stands;
        msg_valid && !msg_ready |=> msg_valid && $stable(msg_kind);
    endproperty
    a_msg_stands: assert property (p_msg_stands)
        else $error("message dropped before accept");
    property p_msix_first;
        msg_valid && msix_en |-> msg_kind == PUIH_MSG_MSIX;
    endproperty
    a_msix_first: assert property (p_msix_first)
        else $error("msix not preferred");
    property p_msi_next;
        msg_valid && msi_en && !msix_en |-> msg_kind == PUIH_MSG_MSI;
    endproperty
    a_msi_next: assert property (p_msi_next)
        else $error("msi not preferred");
    property p_pend;
        pending[USR_W-1:0] == $past(req);
    endproperty
    a_pend: assert property (p_pend)
        else $error("pending does not follow requests");
    property p_req_hold;
        ($past(req) & ~req & ~$past(got_q)) == '0;
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped before ack");
    property p_no_reraise;
        (req & drop_q) == '0;
    endproperty
    a_no_reraise: assert property (p_no_reraise)
        else $error("request raised before second ack");
    property p_deassert_ack;
        leg_only && $fell(req[0]) |-> ##[1:40] ack[0];
    endproperty
    a_deassert_ack: assert property (p_deassert_ack)
        else $error("no second ack after legacy drop");
    c_deassert: cover property (msg_valid
        && msg_kind == PUIH_MSG_LEG_DEASSERT);
    c_msix: cover property (msg_valid && msg_kind == PUIH_MSG_MSIX);
    c_two_req: cover property (req == 4'h3);
endmodule : puih_props

// ==== testbench/testbench.sv ====
/*
 * testbench: both ends joined by the link; user side driven by pulses.
 * assumes: puih_pkg, puih_if and both ends compiled before it.
 */
`timescale 1ns/1ps
module testbench;
    import puih_pkg::*;
    logic clk, rst_n, leg_en, msi_en, msix_en, legacy_mode;
    logic msg_ready, msg_valid;
    logic [USR_W-1:0] raise, serviced, busy;
    logic [DMA_W-1:0] dma_channel_irq;
    logic [SRC_W-1:0] msix_vec_mask, pending, pending_bit_array;
    logic [VEC_W-1:0] msg_vector;
    logic [INTX_W-1:0] msg_intx;
    logic [LINE_N-1:0] intx_level;
    logic [7:0] cfg_addr;
    logic [31:0] cfg_rdata;
    puih_msg_t msg_kind;
    int errors, tests_run;
    int ack_n [USR_W] = '{default: 0};
    puih_if lnk();
    puih_user_end u_puih_user_end (.clk(clk), .rst_n(rst_n), .link(lnk),
        .legacy_mode(legacy_mode), .raise(raise), .serviced(serviced),
        .busy(busy));
    // vectors 0a,05,06,07,11,1f for sources 0..5; source 0 INTB, 1 INTD
    puih_dev_end u_puih_dev_end (.clk(clk), .rst_n(rst_n), .link(lnk),
        .dma_channel_irq(dma_channel_irq), .leg_en(leg_en),
        .msi_en(msi_en), .msix_en(msix_en), .intx_map(12'h00d),
        .vec_map({5'h1f, 5'h11, 5'h07, 5'h06, 5'h05, 5'h0a}),
        .msix_vec_mask(msix_vec_mask), .msg_ready(msg_ready),
        .msg_valid(msg_valid), .msg_kind(msg_kind),
        .msg_vector(msg_vector), .msg_intx(msg_intx),
        .intx_level(intx_level), .cfg_addr(cfg_addr),
        .cfg_rdata(cfg_rdata), .pending(pending),
        .pending_bit_array(pending_bit_array));
    puih_props u_props (.clk(clk), .rst_n(rst_n),
        .engine_user_interrupt_request(lnk.engine_user_interrupt_request),
        .user_interrupt_ack(lnk.user_interrupt_ack), .leg_en(leg_en),
        .msi_en(msi_en), .msix_en(msix_en), .msg_valid(msg_valid),
        .msg_ready(msg_ready), .msg_kind(msg_kind), .pending(pending));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        for (int i = 0; i < USR_W; i++) begin
            if (lnk.user_interrupt_ack[i] === 1'b1) ack_n[i]++;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %0h want %0h", $time,
                seen, exp);
        end
    endtask : check
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done
    task automatic set_mode(input logic l, input logic m, input logic x);
        @(posedge clk);
        leg_en <= l;
        msi_en <= m;
        msix_en <= x;
        legacy_mode <= l & !m & !x;
    endtask : set_mode
    task automatic pulse(input logic svc, input logic [USR_W-1:0] b);
        @(posedge clk);
        if (svc) serviced <= b;
        else raise <= b;
        @(posedge clk);
        serviced <= '0;
        raise <= '0;
    endtask : pulse
    // core side: optional stall, then ready held to the sampling edge
    task automatic take(input puih_msg_t k, input logic [VEC_W-1:0] v,
            input logic [INTX_W-1:0] x, input int stall);
        int n;
        n = 0;
        @(negedge clk);
        while (msg_valid !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        if (n == 40) begin
            errors++;
            $display("CHECK FAILED at %0t: no message", $time);
            test_done();
        end
        repeat (stall) @(negedge clk);
        check(msg_valid, 32'h1);
        check(msg_kind, k);
        if (k == PUIH_MSG_MSI || k == PUIH_MSG_MSIX) begin
            check(msg_vector, v);
        end else begin
            check(msg_intx, x);
        end
        @(posedge clk);
        msg_ready <= 1'b1;
        @(posedge clk);
        msg_ready <= 1'b0;
        repeat (2) @(negedge clk);
    endtask : take
    task automatic rd_cfg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        cfg_addr <= a;
        @(posedge clk);
        @(negedge clk);
        check(cfg_rdata, exp);
    endtask : rd_cfg
    task automatic t_msi;
        rd_cfg(CFG_OFS_MODE, 32'h0);
        set_mode(1'b0, 1'b1, 1'b0);
        pulse(1'b0, 4'h1);
        take(PUIH_MSG_MSI, 5'h0a, 2'h0, 3);
        check(busy, 32'h1);
        check(ack_n[0], 32'h1);
        rd_cfg(CFG_OFS_PEND, 32'h1);
        rd_cfg(CFG_OFS_MODE, 32'h3);
        pulse(1'b1, 4'h1);
        repeat (6) @(negedge clk);
        check(msg_valid, 32'h0);
        check(ack_n[0], 32'h1);
        check(busy, 32'h0);
        rd_cfg(CFG_OFS_PEND, 32'h0);
        $display("test msi done");
    endtask : t_msi
    task automatic t_leg;
        set_mode(1'b1, 1'b0, 1'b0);
        pulse(1'b0, 4'h3);
        take(PUIH_MSG_LEG_ASSERT, 5'h00, 2'h1, 0);
        take(PUIH_MSG_LEG_ASSERT, 5'h00, 2'h3, 1);
        check(intx_level, 32'ha);
        check(ack_n[1], 32'h1);
        check(busy, 32'h3);
        rd_cfg(CFG_OFS_MODE, 32'h1);
        rd_cfg(CFG_OFS_INTX, 32'h00d);
        pulse(1'b1, 4'h3);
        take(PUIH_MSG_LEG_DEASSERT, 5'h00, 2'h1, 0);
        take(PUIH_MSG_LEG_DEASSERT, 5'h00, 2'h3, 0);
        check(ack_n[0], 32'h3);
        check(ack_n[1], 32'h2);
        check(intx_level, 32'h0);
        check(busy, 32'h0);
        $display("test legacy done");
    endtask : t_leg
    task automatic t_msix;
        set_mode(1'b1, 1'b1, 1'b1);
        @(posedge clk);
        dma_channel_irq <= 2'h1;
        take(PUIH_MSG_MSIX, 5'h11, 2'h0, 2);
        check(pending_bit_array, 32'h10);
        rd_cfg(CFG_OFS_PEND_ARR, 32'h10);
        rd_cfg(CFG_OFS_MODE, 32'h2);
        pulse(1'b0, 4'h4);
        take(PUIH_MSG_MSIX, 5'h06, 2'h0, 0);
        check(ack_n[2], 32'h1);
        @(posedge clk);
        dma_channel_irq <= 2'h0;
        pulse(1'b1, 4'h4);
        repeat (4) @(negedge clk);
        check(pending, 32'h0);
        check(pending_bit_array, 32'h0);
        check(msg_valid, 32'h0);
        $display("test msix done");
    endtask : t_msix
    initial begin
        rst_n = 1'b0;
        {leg_en, msi_en, msix_en, legacy_mode, msg_ready} = 5'h00;
        raise = '0;
        serviced = '0;
        dma_channel_irq = '0;
        msix_vec_mask = 6'h10;
        cfg_addr = 8'h00;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_msi();
        t_leg();
        t_msix();
        test_done();
    end
endmodule : testbench
